// *** design/l0rc_pkg.sv ***
// shared constants and types for the level-0 rate control block
package l0rc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_RO_TIME  = 8'h08;
   localparam logic [7:0] OFS_LOW_WM   = 8'h0c;
   localparam logic [7:0] OFS_HIGH_WM  = 8'h10;
   localparam logic [7:0] OFS_OCCUP    = 8'h14;
   localparam logic [7:0] OFS_EXT_CNT  = 8'h18;
   localparam logic [7:0] OFS_GAP_LEN  = 8'h1c;
   localparam logic [7:0] OFS_LIMIT    = 8'h20;
   localparam logic [7:0] OFS_EVENT_ID = 8'h24;
   localparam logic [7:0] OFS_MAP_PTR  = 8'h28;
   localparam logic [7:0] OFS_MAP_WORD = 8'h2c;
   // control bit positions
   localparam int CTRL_STOP    = 0;
   localparam int CTRL_EMU_EN  = 1;
   localparam int CTRL_A_EN    = 2;
   localparam int CTRL_B_EN    = 3;
   localparam int CTRL_SW_THR  = 4;
   localparam int CTRL_LIM_EN  = 5;
   localparam int CTRL_MAP_EN  = 6;
   localparam int CTRL_EMU_RST = 7;
   localparam logic [6:0] CTRL_RESET = 7'h01; // stop set after reset
   // crossing map
   localparam int          MAP_DEPTH = 3564;
   localparam logic [11:0] MAP_LAST  = 12'(MAP_DEPTH - 1);
   // trigger type codes
   localparam logic [2:0] TT_NONE     = 3'h0;
   localparam logic [2:0] TT_PHYSICS  = 3'h1;
   localparam logic [2:0] TT_AUX      = 3'h2;
   localparam logic [2:0] TT_RANDOM   = 3'h3;
   localparam logic [2:0] TT_PERIODIC = 3'h4;
   localparam logic [2:0] TT_TIMING   = 3'h6;
   localparam logic [2:0] TT_CALIB    = 3'h7;

   // software control bits
   typedef struct packed {
      logic map_en;
      logic lim_en;
      logic sw_thr;
      logic b_en;
      logic a_en;
      logic emu_en;
      logic stop;
   } l0rc_ctrl_t;

   // trigger requests of one crossing
   typedef struct packed {
      logic calib;
      logic timing;
      logic periodic;
      logic random;
      logic aux;
      logic physics;
   } l0rc_req_t;

   // whole state of the rate control block
   typedef struct packed {
      l0rc_ctrl_t  ctrl;
      logic [15:0] ro_time;
      logic [15:0] low_wm;
      logic [15:0] high_wm;
      logic [15:0] gap_len;
      logic [31:0] limit;
      logic [11:0] ptr;
      logic [15:0] occ;
      logic [15:0] rot;
      logic        emu_thr;
      logic        a_s1;
      logic        a_s2;
      logic        b_s1;
      logic        b_s2;
      logic [31:0] ext_cnt;
      logic [15:0] gap_cnt;
      logic [31:0] acc_cnt;
      logic        lim_hit;
      logic [31:0] eid;
      logic        accept;
      logic [2:0]  ttype;
      logic [7:0]  raw;
      logic [7:0]  gated;
      logic [1:0]  kind;
      logic        thr_stat;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } l0rc_state_t;
endpackage

// *** design/l0rc_crossing_map.sv ***
// crossing-type memory, one 2-bit word per crossing of a turn
`timescale 1ns/100ps
module l0rc_crossing_map
   import l0rc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        we,
   input  wire logic [11:0] addr,
   input  wire logic [1:0]  wdata,
   output logic      [1:0]  rdata_q
);
   logic [1:0] mem [0:MAP_DEPTH-1];

   // storage array, no reset on the contents
   always_ff @(posedge pclk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= 2'h0;
      end
      else
      begin
         rdata_q <= mem[addr];
      end
   end
endmodule

// *** design/l0rc_rate_control.sv ***
// level-0 throttle, priority handler, event id and crossing map
//
// Operation
// R1 - enabled throttles merge; global blocks accepts
// R2 - each source enabled separately, raw status visible
// R3 - occupancy up on accept, down per readout
// R4 - throttle at high mark, release at low
// R5 - emulator always runs; enable gates output only
// R6 - emulator reset by soft bit, electronics resets
// R7 - two external throttles, each enable and status
// R8 - count cycles while any external throttle active
// R9 - software throttle bit blocks until cleared
// R10 - nonzero gap blocks triggers after each accept
// R11 - accept limit blocks and flags, stop untouched
// R12 - software programs limit only while stopped; the code accepts limit writes at any time
// R13 - limit count restarts when stop clears
// R14 - software sets stop after automatic stop
// R15 - three-bit trigger type codes
// R16 - highest priority type wins on one crossing
// R17 - physics only when no other source fired
// R18 - throttle applied; raw and gated pulses per type
// R19 - stop bit blocks all triggers
// R20 - accept drives decision, counters, fifo, event record
// R21 - 32-bit event id, synchronous clears
// R22 - 3564-entry crossing map, kind logged per accept
// R23 - pointer then words, writes only while disabled
// R24 - occupancy never below zero
// R25 - pointer wraps; follows crossing counter in operation
`timescale 1ns/100ps
module l0rc_rate_control
   import l0rc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire l0rc_req_t   trig_req,
   input  wire logic        ext_throttle_a,
   input  wire logic        ext_throttle_b,
   input  wire logic        l0_elec_reset,
   input  wire logic        l1_elec_reset,
   input  wire logic        event_count_reset,
   input  wire logic [11:0] crossing_id,
   output logic             l0_accept,
   output logic      [2:0]  l0_type,
   output logic      [7:0]  raw_count_pulse,
   output logic      [7:0]  gated_count_pulse,
   output logic      [23:0] event_id_low,
   output logic      [1:0]  crossing_kind,
   output logic             global_throttle_status
);
   l0rc_state_t s_q;
   l0rc_state_t s_d;
   logic [1:0]  map_rdata;
   logic        map_we;
   logic [11:0] map_addr;
   logic        glob;
   logic        any_req;
   logic        acc;
   logic        dec;
   logic        emu_clr;
   logic [2:0]  tsel;
   logic [6:0]  status;

   // crossing-type memory
   l0rc_crossing_map u_map (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (map_we),
      .addr    (map_addr),
      .wdata   (pwdata[1:0]),
      .rdata_q (map_rdata)
   );

   // outputs straight from state
   assign prdata                 = s_q.prdata;
   assign pready                 = s_q.pready;
   assign pslverr                = s_q.pslverr;
   assign l0_accept              = s_q.accept;
   assign l0_type                = s_q.ttype;
   assign raw_count_pulse        = s_q.raw;
   assign gated_count_pulse      = s_q.gated;
   assign event_id_low           = s_q.eid[23:0];
   assign crossing_kind          = s_q.kind;
   assign global_throttle_status = s_q.thr_stat;

   // global throttle and raw status
   always_comb
   begin
      glob = (s_q.ctrl.emu_en & s_q.emu_thr)                // [R1] [R5]
           | (s_q.ctrl.a_en & s_q.a_s2)                     // [R2] [R7]
           | (s_q.ctrl.b_en & s_q.b_s2)
           | s_q.ctrl.sw_thr                                // [R9]
           | (s_q.gap_cnt != 16'h0000)                      // [R10]
           | (s_q.ctrl.lim_en & s_q.lim_hit);               // [R11]
      // raw source states for the status word
      status = {s_q.lim_hit, s_q.gap_cnt != 16'h0000, s_q.ctrl.sw_thr,
                s_q.b_s2, s_q.a_s2, s_q.emu_thr, glob};     // [R2]
   end

   // priority selection, highest code first
   always_comb
   begin
      if (trig_req.calib)
         tsel = TT_CALIB;                                   // [R15] [R16]
      else if (trig_req.timing)
         tsel = TT_TIMING;
      else if (trig_req.periodic)
         tsel = TT_PERIODIC;
      else if (trig_req.random)
         tsel = TT_RANDOM;
      else if (trig_req.aux)
         tsel = TT_AUX;
      else if (trig_req.physics)
         tsel = TT_PHYSICS;                                 // [R17]
      else
         tsel = TT_NONE;
      // any request counts raw; stop and throttle gate the accept
      any_req = |trig_req;
      acc     = any_req && !glob && !s_q.ctrl.stop;         // [R18] [R19]
      emu_clr = l0_elec_reset || l1_elec_reset ||
                (psel && penable && pwrite && s_q.pready &&
                 paddr == OFS_CTRL && pwdata[CTRL_EMU_RST]); // [R6]
      map_we   = psel && penable && pwrite && s_q.pready &&
                 paddr == OFS_MAP_WORD && !s_q.ctrl.map_en;  // [R23]
      // software owns the pointer while the map is disabled
      map_addr = s_q.ctrl.map_en ? crossing_id : s_q.ptr;   // [R25]
   end

   // next-state logic
   always_comb
   begin
      s_d = s_q;
      dec = 1'b0;
      // external throttle synchronisers
      s_d.a_s1 = ext_throttle_a;
      s_d.a_s2 = s_q.a_s1;
      s_d.b_s1 = ext_throttle_b;
      s_d.b_s2 = s_q.b_s1;
      if (s_q.a_s2 || s_q.b_s2)
         s_d.ext_cnt = s_q.ext_cnt + 32'h1;                  // [R8]
      // emulated readout timer
      if (s_q.occ != 16'h0000)
      begin
         if (s_q.rot >= s_q.ro_time)
         begin
            dec      = 1'b1;                                 // [R24]
            s_d.rot  = 16'h0000;
         end
         else
            s_d.rot = s_q.rot + 16'h1;
      end
      else
         s_d.rot = 16'h0000;
      s_d.occ = 16'(s_q.occ + {15'h0, acc} - {15'h0, dec}); // [R3] [R5]
      if (s_d.occ >= s_q.high_wm)
         s_d.emu_thr = 1'b1;                                 // [R4]
      else if (s_d.occ <= s_q.low_wm)
         s_d.emu_thr = 1'b0;
      // soft or electronics reset empties the emulator
      if (emu_clr)
      begin
         s_d.occ     = 16'h0000;                             // [R6]
         s_d.rot     = 16'h0000;
         s_d.emu_thr = 1'b0;
      end
      // forced gap after each accept
      if (acc)
         s_d.gap_cnt = s_q.gap_len;                          // [R10]
      else if (s_q.gap_cnt != 16'h0000)
         s_d.gap_cnt = s_q.gap_cnt - 16'h1;
      // accept limit
      if (acc && s_q.ctrl.lim_en)
      begin
         s_d.acc_cnt = s_q.acc_cnt + 32'h1;
         if (s_q.acc_cnt + 32'h1 >= s_q.limit)
            s_d.lim_hit = 1'b1;                              // [R11]
      end
      // event identifier
      if (event_count_reset || l0_elec_reset || l1_elec_reset)
         s_d.eid = 32'h0;                                    // [R21]
      else if (acc)
         s_d.eid = s_q.eid + 32'h1;                          // [R20]
      // global throttle status, registered for the pin
      s_d.thr_stat = glob;                                   // [R1]
      // decision and count pulses
      s_d.accept = acc;                                      // [R20]
      s_d.ttype  = acc ? tsel : TT_NONE;
      s_d.raw    = any_req ? 8'(8'h01 << tsel) : 8'h00;      // [R18]
      s_d.gated  = acc ? 8'(8'h01 << tsel) : 8'h00;
      if (acc)
         s_d.kind = map_rdata;                               // [R22]
      // register bus, one wait state
      s_d.pready  = psel && penable && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0;
      // reads only: a write to a hole must not raise the error flag
      if (psel && penable && !pwrite && !s_q.pready)
      begin
         case (paddr)
            OFS_CTRL:     s_d.prdata = {25'h0, s_q.ctrl};
            OFS_STATUS:   s_d.prdata = {25'h0, status};     // [R1] [R2]
            OFS_RO_TIME:  s_d.prdata = {16'h0, s_q.ro_time};
            OFS_LOW_WM:   s_d.prdata = {16'h0, s_q.low_wm};
            OFS_HIGH_WM:  s_d.prdata = {16'h0, s_q.high_wm};
            OFS_OCCUP:    s_d.prdata = {16'h0, s_q.occ};     // [R5]
            OFS_EXT_CNT:  s_d.prdata = s_q.ext_cnt;
            OFS_GAP_LEN:  s_d.prdata = {16'h0, s_q.gap_len};
            OFS_LIMIT:    s_d.prdata = s_q.limit;
            OFS_EVENT_ID: s_d.prdata = s_q.eid;
            OFS_MAP_PTR:  s_d.prdata = {20'h0, s_q.ptr};
            OFS_MAP_WORD: s_d.prdata = {30'h0, map_rdata};
            default:      s_d.pslverr = 1'b1;
         endcase
      end
      // writes land on the edge that completes the transfer
      if (psel && penable && s_q.pready && pwrite)
      begin
         case (paddr)
            OFS_CTRL:
            begin
               s_d.ctrl = l0rc_ctrl_t'(pwdata[6:0]);
               if (s_q.ctrl.stop && !pwdata[CTRL_STOP])
               begin
                  s_d.acc_cnt = 32'h0;                       // [R13]
                  s_d.lim_hit = 1'b0;
               end
            end
            OFS_RO_TIME: s_d.ro_time = pwdata[15:0];
            OFS_LOW_WM:  s_d.low_wm  = pwdata[15:0];
            OFS_HIGH_WM: s_d.high_wm = pwdata[15:0];
            OFS_GAP_LEN: s_d.gap_len = pwdata[15:0];
            OFS_LIMIT:   s_d.limit   = pwdata;
            OFS_MAP_PTR: s_d.ptr     = pwdata[11:0] > MAP_LAST ? 12'h000 : pwdata[11:0];
            default:     s_d.pslverr = 1'b0;
         endcase
      end
      // pointer advances on every word access
      if (psel && penable && s_q.pready && paddr == OFS_MAP_WORD)
         s_d.ptr = (s_q.ptr == MAP_LAST) ? 12'h000 : s_q.ptr + 12'h1; // [R23] [R25]
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q      <= '0;
         s_q.ctrl <= l0rc_ctrl_t'(CTRL_RESET);
      end
      else
      begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   global_blocks_a: assert property (glob |=> !s_q.accept) // [R1]
      else $error("accept passed under global throttle");
   source_enable_a: assert property ((!s_q.ctrl.emu_en && !s_q.ctrl.a_en && !s_q.ctrl.b_en && !s_q.ctrl.sw_thr
      && s_q.gap_cnt == 16'h0000 && !s_q.ctrl.lim_en) |-> !glob) // [R2]
      else $error("disabled source throttled");
   occ_rise_a: assert property ((acc && !dec && !emu_clr) |=> s_q.occ == $past(s_q.occ) + 16'h1) // [R3]
      else $error("occupancy did not rise on accept");
   hyst_hold_a: assert property ((s_q.emu_thr && s_q.occ > s_q.low_wm + 16'h1 && !emu_clr) |=> s_q.emu_thr) // [R4]
      else $error("emulator throttle released above low mark");
   emu_reset_a: assert property (emu_clr |=> s_q.occ == 16'h0000 && !s_q.emu_thr) // [R6]
      else $error("emulator not cleared");
   ext_count_a: assert property ((s_q.a_s2 || s_q.b_s2) |=> s_q.ext_cnt == $past(s_q.ext_cnt) + 32'h1) // [R8]
      else $error("external throttle time not counted");
   gap_block_a: assert property ((acc && s_q.gap_len != 16'h0000) |=> !acc) // [R10]
      else $error("accept inside forced gap");
   stop_block_a: assert property (s_q.ctrl.stop |=> !s_q.accept) // [R19]
      else $error("accept while stopped");
   calib_wins_a: assert property ((trig_req.calib && acc) |=> s_q.ttype == TT_CALIB) // [R16]
      else $error("calibration lost priority");
   occ_floor_a: assert property ((s_q.occ == 16'h0000 && !acc) |=> s_q.occ == 16'h0000) // [R24]
      else $error("occupancy went below zero");
   eid_clear_a: assert property ((event_count_reset || l0_elec_reset) |=> s_q.eid == 32'h0) // [R21]
      else $error("event id not cleared");
   gated_pair_a: assert property (s_q.accept |-> s_q.gated == s_q.raw && s_q.gated != 8'h00) // [R18]
      else $error("gated pulse mismatch");

   // throttle sources and the global status pin
   sw_throttle_a: assert property (s_q.ctrl.sw_thr |-> glob) // [R9]
      else $error("software throttle ignored");
   status_pin_a: assert property (global_throttle_status == $past(glob)) // [R1]
      else $error("status pin out of step");
   ext_sync_a: assert property (s_q.a_s2 == $past(s_q.a_s1) // [R7]
      && s_q.b_s2 == $past(s_q.b_s1))
      else $error("throttle pin skipped a stage");
   ext_hold_a: assert property ((!s_q.a_s2 && !s_q.b_s2) |=> $stable(s_q.ext_cnt)) // [R8]
      else $error("throttle time counted while idle");
   gap_idle_a: assert property ((s_q.gap_len == 16'h0000 && s_q.gap_cnt == 16'h0000) // [R10]
      |=> s_q.gap_cnt == 16'h0000)
      else $error("gap opened with zero length");
   limit_block_a: assert property ((s_q.ctrl.lim_en && s_q.lim_hit) |-> !acc) // [R11]
      else $error("accept past the limit");
   limit_arm_a: assert property ((s_q.ctrl.stop && !pwdata[CTRL_STOP] && paddr == OFS_CTRL // [R13]
      && psel && penable && pwrite && s_q.pready) |=> (s_q.acc_cnt == 32'h0 && !s_q.lim_hit))
      else $error("limit count not restarted");

   // emulator occupancy
   occ_fall_a: assert property ((dec && !acc && !emu_clr) |=> s_q.occ == $past(s_q.occ) - 16'h1) // [R3]
      else $error("occupancy did not fall on readout");
   emu_set_a: assert property ((s_q.occ >= s_q.high_wm && s_q.occ != 16'h0000 && !dec // [R4]
      && !emu_clr) |=> s_q.emu_thr)
      else $error("emulator throttle not raised");

   // priority handler and decision
   type_code_a: assert property (s_q.accept |-> (s_q.ttype != TT_NONE && s_q.ttype != 3'h5)) // [R15]
      else $error("accept with a reserved type");
   physics_alone_a: assert property ((s_q.accept && s_q.ttype == TT_PHYSICS) // [R17]
      |-> $past(trig_req) == l0rc_req_t'(6'h01))
      else $error("physics tag with other sources");
   stop_resume_a: assert property ((!s_q.ctrl.stop && !glob && |trig_req) |=> s_q.accept) // [R19]
      else $error("trigger lost while running");
   raw_onehot_a: assert property ((|trig_req) |=> $onehot(s_q.raw)) // [R18]
      else $error("raw pulse not one-hot");
   eid_step_a: assert property ((acc && !event_count_reset && !l0_elec_reset && !l1_elec_reset) // [R20]
      |=> s_q.eid == $past(s_q.eid) + 32'h1)
      else $error("event id did not advance");

   // crossing map
   kind_log_a: assert property (s_q.accept |-> s_q.kind == $past(map_rdata)) // [R22]
      else $error("crossing kind not logged");
   map_lock_a: assert property (s_q.ctrl.map_en |-> !map_we) // [R23]
      else $error("map written while enabled");
   ptr_wrap_a: assert property ((s_q.ptr == MAP_LAST && map_we) |=> s_q.ptr == 12'h000) // [R25]
      else $error("map pointer did not wrap");

   // main scenarios
   accept_c: cover property (s_q.accept ##1 s_q.accept);
   emu_thr_c: cover property ($rose(s_q.emu_thr));
   limit_c: cover property ($rose(s_q.lim_hit));
   map_wrap_c: cover property (map_we && s_q.ptr == MAP_LAST);
   ext_both_c: cover property (s_q.a_s2 && s_q.b_s2);
endmodule

// *** testbench/l0rc_far_side.sv ***
// far-side model: trigger sources and readout-board throttle lines
`timescale 1ns/100ps
module l0rc_far_side
   import l0rc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire l0rc_req_t  req_cmd,
   input  wire logic [1:0] thr_cmd,
   output l0rc_req_t       trig_req,
   output logic            ext_throttle_a,
   output logic            ext_throttle_b
);
   // requests and throttles change just after a rising edge, held a full cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_req       <= '0;
         ext_throttle_a <= 1'b0;
         ext_throttle_b <= 1'b0;
      end
      else
      begin
         trig_req       <= req_cmd;    // one crossing per cycle
         ext_throttle_a <= thr_cmd[0]; // driven low when the board is idle
         ext_throttle_b <= thr_cmd[1];
      end
   end
endmodule

// *** testbench/l0_trigger_rate_control_tb.sv ***
// self-checking bench for the level-0 rate control block
`timescale 1ns/100ps
module l0_trigger_rate_control_tb;
   import l0rc_pkg::*;
   localparam l0rc_req_t AUX = 6'h02;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        l0r = 1'b0, l1r = 1'b0, ecr = 1'b0, acc, glob, pready, pslverr, ext_a, ext_b, er;
   logic [7:0]  paddr = 8'h00, rs, gs, rawp, gatp;
   logic [31:0] pwdata = 32'h0, prdata, rd, c0;
   logic [11:0] xid = 12'h000;
   logic [2:0]  ttype, lt;
   logic [2:0]  codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
   logic [1:0]  kind, lk, thr = 2'b00;
   logic [23:0] eidl;
   l0rc_req_t   req = '0, trig_req;
   int          fail_count = 0, num_checks = 0, cyc = 0, accs = 0;

   // free-running 100 MHz clock
   always #5 pclk = ~pclk;

   l0rc_far_side far (.pclk(pclk), .presetn(presetn), .req_cmd(req), .thr_cmd(thr), .trig_req(trig_req),
      .ext_throttle_a(ext_a), .ext_throttle_b(ext_b));
   l0rc_rate_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_req(trig_req), .ext_throttle_a(ext_a), .ext_throttle_b(ext_b), .l0_elec_reset(l0r),
      .l1_elec_reset(l1r), .event_count_reset(ecr), .crossing_id(xid), .l0_accept(acc), .l0_type(ttype),
      .raw_count_pulse(rawp), .gated_count_pulse(gatp), .event_id_low(eidl), .crossing_kind(kind),
      .global_throttle_status(glob));

   // accept monitor and timeout
   always @(posedge pclk)
   begin
      cyc++;
      rs |= rawp;
      gs |= gatp;
      if (acc === 1'b1)
      begin
         accs++;
         lt = ttype;
         lk = kind;
      end
      if (cyc == 20000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer, request held until pready is seen at a rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // values read here are those that stood up to this edge
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 50)
         fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdm(string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd & m, exp);
   endtask

   // hold a request n crossings, then let the pipeline empty
   task automatic trig(l0rc_req_t r, int n);
      accs = 0;
      rs = 8'h00;
      gs = 8'h00;
      req <= r;
      repeat (n) @(posedge pclk);
      req <= '0;
      repeat (3) @(posedge pclk);
   endtask

   // main sequence
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdm("ctrl reset", OFS_CTRL, 32'hff, 32'h01);
      rdm("event id reset", OFS_EVENT_ID, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", er, 1);
      trig(AUX, 1);
      chk("accepts while stopped", accs, 0);
      chk("raw while stopped", rs, 8'h04);
      chk("gated while stopped", gs, 8'h00);
      wr(OFS_CTRL, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         trig(l0rc_req_t'(6'((2 << i) - 1)), 1);
         chk("priority type", lt, codes[i]);
         chk("gated pulse", gs, 8'h01 << codes[i]);
      end
      chk("event id low", eidl, 24'd6);
      wr(OFS_CTRL, 32'h10);
      trig(AUX, 1);
      chk("sw throttle", accs, 0);
      rdm("sw status", OFS_STATUS, 32'h11, 32'h11);
      chk("global pin on", glob, 1);
      wr(OFS_CTRL, 32'h0);
      trig(AUX, 1);
      chk("sw released", accs, 1);
      chk("global pin off", glob, 0);
      wr(OFS_GAP_LEN, 32'h2);
      trig(AUX, 6);
      chk("gap of two", accs, 2);
      wr(OFS_GAP_LEN, 32'h0);
      trig(AUX, 4);
      chk("gap off", accs, 4);
      rdm("event id", OFS_EVENT_ID, 32'hffffffff, 32'd13);
      // emulator counts while its throttle is disabled
      wr(OFS_RO_TIME, 32'hffff);
      wr(OFS_LOW_WM, 32'h1);
      wr(OFS_HIGH_WM, 32'h3);
      wr(OFS_CTRL, 32'h80);
      rdm("occupancy soft reset", OFS_OCCUP, 32'hffff, 32'h0);
      repeat (4) trig(AUX, 1);
      rdm("occupancy", OFS_OCCUP, 32'hffff, 32'h4);
      rdm("emu status off", OFS_STATUS, 32'h03, 32'h02);
      wr(OFS_CTRL, 32'h02);
      trig(AUX, 1);
      chk("emu throttle", accs, 0);
      rdm("emu status on", OFS_STATUS, 32'h03, 32'h03);
      wr(OFS_RO_TIME, 32'h3);
      repeat (40) @(posedge pclk);
      rdm("occupancy drained", OFS_OCCUP, 32'hffff, 32'h0);
      rdm("emu released", OFS_STATUS, 32'h03, 32'h00);
      wr(OFS_RO_TIME, 32'hffff);
      wr(OFS_CTRL, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         trig(AUX, 1);
         l0r <= (k == 0);
         l1r <= (k == 1);
         ecr <= (k == 2);
         @(posedge pclk);
         {l0r, l1r, ecr} <= 3'b000;
         @(posedge pclk);
         rdm("event id clear", OFS_EVENT_ID, 32'hffffffff, 32'h0);
         if (k < 2)
            rdm("occupancy clear", OFS_OCCUP, 32'hffff, 32'h0);
      end
      // external throttles
      rdm("ext status idle", OFS_STATUS, 32'h0c, 32'h0);
      c0 = rd;
      apb(1'b0, OFS_EXT_CNT, 32'h0);
      c0 = rd;
      thr <= 2'b11;
      repeat (10) @(posedge pclk);
      thr <= 2'b00;
      repeat (5) @(posedge pclk);
      rdm("ext cycles", OFS_EXT_CNT, 32'hffffffff, c0 + 32'd10);
      wr(OFS_CTRL, 32'h04);
      thr <= 2'b10;
      repeat (4) @(posedge pclk); // let the pin pass its synchroniser
      trig(AUX, 1);
      chk("disabled b", accs, 1);
      rdm("ext b status", OFS_STATUS, 32'h0d, 32'h08);
      thr <= 2'b01;
      repeat (4) @(posedge pclk); // let the pin pass its synchroniser
      trig(AUX, 1);
      chk("enabled a", accs, 0);
      rdm("ext a status", OFS_STATUS, 32'h0d, 32'h05);
      thr <= 2'b00;
      // automatic stop, programmed while stopped
      wr(OFS_CTRL, 32'h01);
      wr(OFS_LIMIT, 32'h3);
      wr(OFS_CTRL, 32'h21);
      wr(OFS_CTRL, 32'h20);
      trig(AUX, 8);
      chk("limit accepts", accs, 3);
      rdm("limit status", OFS_STATUS, 32'h40, 32'h40);
      rdm("stop untouched", OFS_CTRL, 32'h01, 32'h00);
      wr(OFS_CTRL, 32'h21);
      wr(OFS_CTRL, 32'h20);
      trig(AUX, 2);
      chk("limit rearmed", accs, 2);
      // crossing map load with wrap
      wr(OFS_CTRL, 32'h01);
      wr(OFS_MAP_PTR, 32'd3563);
      wr(OFS_MAP_WORD, 32'h3);
      wr(OFS_MAP_WORD, 32'h1);
      wr(OFS_MAP_WORD, 32'h2);
      wr(OFS_MAP_PTR, 32'd3563);
      apb(1'b0, OFS_CTRL, 32'h0);
      rdm("map last", OFS_MAP_WORD, 32'hffffffff, 32'h3);
      rdm("map wrap", OFS_MAP_WORD, 32'hffffffff, 32'h1);
      rdm("map next", OFS_MAP_WORD, 32'hffffffff, 32'h2);
      wr(OFS_CTRL, 32'h40);
      xid <= 12'd3563;
      trig(AUX, 2);
      chk("crossing kind", lk, 2'h3);
      wr(OFS_MAP_PTR, 32'd3563);
      wr(OFS_MAP_WORD, 32'h0);
      wr(OFS_CTRL, 32'h01);
      wr(OFS_MAP_PTR, 32'd3563);
      apb(1'b0, OFS_CTRL, 32'h0);
      rdm("map write refused", OFS_MAP_WORD, 32'hffffffff, 32'h3);
      test_done();
   end
endmodule
